// ===== hdl/charger_regs_pkg.sv
// Package with the constants, codes and types of the run-time charger register bank.
package charger_regs_pkg;

  // Register byte addresses on the internal XDATA map.
  localparam logic [15:0] ADDR_RESULT = 16'h30e2;
  localparam logic [15:0] ADDR_CUST_CTL = 16'h30e3;
  localparam logic [15:0] ADDR_CUST_STAT = 16'h30e4;
  localparam logic [15:0] ADDR_PWR_STAT = 16'h30e5;
  localparam logic [15:0] ADDR_OVERCURRENT_STATUS = 16'h30e6;
  localparam logic [15:0] ADDR_MODE = 16'h30ec;
  localparam logic [15:0] ADDR_MASK = 16'h30ed;
  localparam logic [15:0] ADDR_PORTABLE_HUB_CONFIG = 16'h30ee;
  localparam logic [15:0] ADDR_PORT_SELECT_LOW_POWER_SUSPEND = 16'h318b;
  localparam logic [15:0] ADDR_ATTACH = 16'h318e;
  localparam logic [15:0] ADDR_BC1 = 16'h6100;
  localparam logic [15:0] ADDR_BC2 = 16'h6101;
  localparam logic [15:0] ADDR_LIVE = 16'h6102;
  localparam logic [15:0] ADDR_DETECT = 16'h6103;

  // Number of plain read/write bytes and their storage slots.
  localparam int NUM_RW = 10;
  localparam logic [3:0] IDX_MODE = 4'h1;
  localparam logic [3:0] IDX_MASK = 4'h2;

  // Reset values.
  localparam logic [7:0] RESULT_RST = 8'h02;
  localparam logic [7:0] RW_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Field positions in the result register and steering bits elsewhere.
  localparam int TYPE_LSB = 5;
  localparam int DONE_BIT = 4;
  localparam int RSVD_BIT = 3;
  localparam int BUDGET_LSB = 1;
  localparam int START_BIT = 0;
  localparam int EXT_SEL_BIT = 0;
  localparam int MASK_VBUS_BIT = 0;
  localparam int MASK_CFG_BIT = 1;
  localparam int MASK_CHG_BIT = 2;

  // Charger type codes.
  localparam logic [2:0] TYPE_NOT_DONE = 3'h0;
  localparam logic [2:0] TYPE_DCP = 3'h1;
  localparam logic [2:0] TYPE_CDP = 3'h2;
  localparam logic [2:0] TYPE_DISABLED = 3'h7;

  // Current budget codes.
  localparam logic [1:0] BUDGET_NONE = 2'h0;
  localparam logic [1:0] BUDGET_100MA = 2'h1;
  localparam logic [1:0] BUDGET_500MA = 2'h2;
  localparam logic [1:0] BUDGET_1A = 2'h3;
  localparam logic [1:0] BUDGET_RST = 2'h1;

  // SMBus command byte that reaches the page register.
  localparam logic [7:0] PAGE_CMD = 8'hff;

  // One register access handed from the link domain to the core.
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } xfer_s;

  // Link-side protocol states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK
  } link_state_e;

endpackage : charger_regs_pkg

// ===== hdl/smbus_runtime_charger_regs.sv
// SMBus slave port with the run-time charger register bank behind it.
`timescale 1ns/10ps
module smbus_runtime_charger_regs
  import charger_regs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2d
)
(
  // Core clock and synchronous active-low reset.
  input wire logic clk,
  input wire logic resetn,
  // SMBus link: sampling clock, clock pin and open-drain data pin.
  input wire logic smbus_link_clk,
  input wire logic smbus_clock_pin,
  input wire logic smbus_serial_data_pin_i,
  output logic smbus_serial_data_pin_o,
  output logic smbus_serial_data_pin_oe,
  output logic smbus_port_enabled,
  // Charger detector handshake.
  output logic detect_start,
  input wire logic detector_done,
  input wire logic [2:0] detector_type,
  input wire logic detector_disabled,
  // Conditions that feed the current budget.
  input wire logic vbus_present,
  input wire logic device_configured,
  input wire logic charger_found,
  // Live status shown in read-only registers.
  input wire logic [3:0] custom_charge_status,
  input wire logic [3:0] port_power_on,
  input wire logic [7:0] overcurrent_flags,
  // Stored control bytes for the rest of the chip.
  output logic [NUM_RW-1:0][7:0] control_bytes
);

  // Maps a register address onto its storage slot, with a hit flag on top.
  function automatic logic [4:0] rw_slot(input logic [15:0] addr);
    unique case (addr)
      ADDR_CUST_CTL: rw_slot = 5'h10;
      ADDR_MODE: rw_slot = 5'h11;
      ADDR_MASK: rw_slot = 5'h12;
      ADDR_PORTABLE_HUB_CONFIG: rw_slot = 5'h13;
      ADDR_PORT_SELECT_LOW_POWER_SUSPEND: rw_slot = 5'h14;
      ADDR_ATTACH: rw_slot = 5'h15;
      ADDR_BC1: rw_slot = 5'h16;
      ADDR_BC2: rw_slot = 5'h17;
      ADDR_LIVE: rw_slot = 5'h18;
      ADDR_DETECT: rw_slot = 5'h19;
      default: rw_slot = 5'h00;
    endcase
  endfunction : rw_slot

  // Folds the detector code into the basic or extended encoding.
  function automatic logic [2:0] type_code(input logic [2:0] raw, input logic ext);
    type_code = (!ext && raw == TYPE_CDP) ? TYPE_DCP : raw;
  endfunction : type_code

  // Core domain state.
  logic [7:0] rw_ff [NUM_RW]; // Plain read/write bytes.
  logic running_ff; // Manual detection in progress.
  logic done_ff; // Detection finished.
  logic [2:0] type_ff; // Reported charger type.
  logic rsvd_ff; // Debug bit, stored only.
  logic [1:0] budget_ff; // Current budget code.
  logic start_pulse_ff; // One-cycle start to the detector.
  logic [7:0] rd_data_ff; // Read answer held for the link.
  logic ack_tgl_ff; // Toggles once per finished access.
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_seen_ff;
  logic en_s1_ff;
  logic en_s2_ff;

  // Link domain state.
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_s3_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_s3_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_seen_ff;
  logic strap_done_ff; // Pull-up sense taken.
  logic enabled_ff; // Port present and enabled.
  link_state_e state_ff, nxt_state;
  link_state_e after_ff, nxt_after;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] shift_ff, nxt_shift;
  logic drive_ff, nxt_drive;
  logic [7:0] page_ff, nxt_page;
  logic [7:0] ptr_ff, nxt_ptr;
  logic rack_ok_ff, nxt_rack_ok;
  logic [7:0] rdata_ff;
  xfer_s req_ff, nxt_req;
  logic req_tgl_ff, nxt_req_tgl;

  // Core decode wires.
  wire logic req_new = req_s2_ff ^ req_seen_ff;
  wire logic wr_en = req_new && req_ff.write;
  wire logic [4:0] slot = rw_slot(req_ff.addr);
  wire logic wr_rw = wr_en && slot[4];
  wire logic wr_result = wr_en && (req_ff.addr == ADDR_RESULT);
  wire logic start_wr = wr_result && req_ff.data[START_BIT];
  wire logic ext_sel = rw_ff[IDX_MODE][EXT_SEL_BIT];
  wire logic [7:0] msk = rw_ff[IDX_MASK];
  wire logic [7:0] result_val = {type_ff, done_ff, rsvd_ff, budget_ff, running_ff};
  wire logic [4:0] rd_slot = rw_slot(req_ff.addr);

  // Budget from the masked conditions, highest current first.
  wire logic [1:0] nxt_budget = (msk[MASK_CHG_BIT] && charger_found) ? BUDGET_1A :
                                (msk[MASK_CFG_BIT] && device_configured) ? BUDGET_500MA :
                                (msk[MASK_VBUS_BIT] && vbus_present) ? BUDGET_100MA :
                                BUDGET_NONE;

  // Read multiplexer; unmapped addresses read as zero.
  logic [7:0] rd_value;
  always_comb
  begin
    rd_value = 8'h00;
    if (rd_slot[4])
    begin
      rd_value = rw_ff[rd_slot[3:0]];
    end
    else
    begin
      unique case (req_ff.addr)
        ADDR_RESULT: rd_value = result_val;
        ADDR_CUST_STAT: rd_value = {4'h0, custom_charge_status};
        ADDR_PWR_STAT: rd_value = {3'h0, port_power_on, 1'b0};
        ADDR_OVERCURRENT_STATUS: rd_value = overcurrent_flags;
        default: rd_value = 8'h00;
      endcase
    end
  end

  // Request toggle from the link crosses in two flops; the struct is stable meanwhile.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_seen_ff <= 1'b0;
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
    end
    else
    begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_seen_ff <= req_s2_ff;
      en_s1_ff <= enabled_ff;
      en_s2_ff <= en_s1_ff;
    end
  end

  // Each access answers with held read data and an acknowledge toggle.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_data_ff <= 8'h00;
      ack_tgl_ff <= 1'b0;
    end
    else if (req_new)
    begin
      rd_data_ff <= rd_value;
      ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  // Plain read/write byte storage.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_RW; i++)
      begin
        rw_ff[i] <= RW_RST;
      end
    end
    else if (wr_rw)
    begin
      rw_ff[slot[3:0]] <= req_ff.data;
    end
  end

  // Detection control; a finish in the same cycle as a start still sets the done flag.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      running_ff <= RESULT_RST[START_BIT];
      done_ff <= RESULT_RST[DONE_BIT];
      type_ff <= RESULT_RST[7:TYPE_LSB];
      rsvd_ff <= RESULT_RST[RSVD_BIT];
      budget_ff <= BUDGET_RST;
      start_pulse_ff <= 1'b0;
    end
    else
    begin
      start_pulse_ff <= start_wr;
      budget_ff <= nxt_budget;
      // Start wins over a finish, so a restart is never lost.
      running_ff <= start_wr ? 1'b1 : (detector_done ? 1'b0 : running_ff);
      done_ff <= detector_done ? 1'b1 : (start_wr ? 1'b0 : done_ff);
      if (detector_disabled)
      begin
        type_ff <= TYPE_DISABLED;
      end
      else if (detector_done)
      begin
        type_ff <= type_code(detector_type, ext_sel);
      end
      else if (start_wr)
      begin
        type_ff <= TYPE_NOT_DONE;
      end
      if (wr_result)
      begin
        rsvd_ff <= req_ff.data[RSVD_BIT];
      end
    end
  end

  // Core outputs.
  assign detect_start = start_pulse_ff;
  assign smbus_port_enabled = en_s2_ff;
  always_comb
  begin
    for (int i = 0; i < NUM_RW; i++)
    begin
      control_bytes[i] = rw_ff[i];
    end
  end

  // Link domain: reset, pins and the acknowledge toggle each pass two flops first.
  always_ff @(posedge smbus_link_clk)
  begin
    lrst_s1_ff <= resetn;
    lrst_s2_ff <= lrst_s1_ff;
    scl_s1_ff <= smbus_clock_pin;
    scl_s2_ff <= scl_s1_ff;
    scl_s3_ff <= scl_s2_ff;
    sda_s1_ff <= smbus_serial_data_pin_i;
    sda_s2_ff <= sda_s1_ff;
    sda_s3_ff <= sda_s2_ff;
    ack_s1_ff <= ack_tgl_ff;
    ack_s2_ff <= ack_s1_ff;
  end

  // Line conditions seen on the synchronised pins.
  wire logic scl_rise = scl_s2_ff && !scl_s3_ff;
  wire logic scl_fall = !scl_s2_ff && scl_s3_ff;
  wire logic start_cond = scl_s2_ff && scl_s3_ff && !sda_s2_ff && sda_s3_ff;
  wire logic stop_cond = scl_s2_ff && scl_s3_ff && sda_s2_ff && !sda_s3_ff;
  wire logic page_hit = (ptr_ff == PAGE_CMD);
  wire logic [7:0] tx_byte = page_hit ? page_ff : rdata_ff;
  wire logic [7:0] ptr_inc = ptr_ff + 8'h01;
  wire logic [3:0] bit_inc = bitcnt_ff + 4'h1;

  // Pull-up sense is taken once after reset; a low data line keeps the port off.
  always_ff @(posedge smbus_link_clk)
  begin
    if (!lrst_s2_ff)
    begin
      strap_done_ff <= 1'b0;
      enabled_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      if (!strap_done_ff)
      begin
        strap_done_ff <= 1'b1;
        enabled_ff <= scl_s2_ff && sda_s2_ff;
      end
      ack_seen_ff <= ack_s2_ff;
      if (ack_s2_ff != ack_seen_ff)
      begin
        rdata_ff <= rd_data_ff;
      end
    end
  end

  // Byte-level slave protocol; reads rely on the core answering within half a bus clock.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_after = after_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_drive = drive_ff;
    nxt_page = page_ff;
    nxt_ptr = ptr_ff;
    nxt_rack_ok = rack_ok_ff;
    nxt_req = req_ff;
    nxt_req_tgl = req_tgl_ff;
    if (!enabled_ff)
    begin
      nxt_state = ST_IDLE;
      nxt_drive = 1'b0;
    end
    else if (start_cond)
    begin
      nxt_state = ST_ADDR;
      nxt_bitcnt = 4'h0;
      nxt_drive = 1'b0;
    end
    else if (stop_cond)
    begin
      nxt_state = ST_IDLE;
      nxt_drive = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          nxt_drive = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise && bitcnt_ff != 4'h8)
          begin
            nxt_shift = {shift_ff[6:0], sda_s2_ff};
            nxt_bitcnt = bit_inc;
          end
          else if (scl_fall && bitcnt_ff == 4'h8)
          begin
            // Acknowledge the byte, except an address byte that names another slave.
            nxt_drive = 1'b1;
            nxt_state = ST_ACK;
            nxt_bitcnt = 4'h0;
            if (state_ff == ST_ADDR)
            begin
              if (shift_ff[7:1] != SLAVE_ADDR)
              begin
                nxt_drive = 1'b0;
                nxt_state = ST_IDLE;
              end
              else if (shift_ff[0])
              begin
                nxt_after = ST_RDATA;
                nxt_req = '{write: 1'b0, addr: {page_ff, ptr_ff}, data: 8'h00};
                nxt_req_tgl = ~req_tgl_ff;
              end
              else
              begin
                nxt_after = ST_CMD;
              end
            end
            else if (state_ff == ST_CMD)
            begin
              nxt_ptr = shift_ff;
              nxt_after = ST_WDATA;
            end
            else
            begin
              nxt_after = ST_WDATA;
              nxt_ptr = ptr_inc;
              if (page_hit)
              begin
                nxt_page = shift_ff;
              end
              else
              begin
                nxt_req = '{write: 1'b1, addr: {page_ff, ptr_ff}, data: shift_ff};
                nxt_req_tgl = ~req_tgl_ff;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            nxt_drive = 1'b0;
            nxt_state = after_ff;
            nxt_bitcnt = 4'h0;
            if (after_ff == ST_RDATA)
            begin
              nxt_shift = tx_byte;
              nxt_drive = ~tx_byte[7];
              nxt_bitcnt = 4'h1;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bitcnt_ff == 4'h8)
            begin
              nxt_drive = 1'b0;
              nxt_state = ST_RACK;
            end
            else
            begin
              nxt_drive = ~shift_ff[6];
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_bitcnt = bit_inc;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            nxt_rack_ok = !sda_s2_ff;
            if (!sda_s2_ff)
            begin
              nxt_ptr = ptr_inc;
              nxt_req = '{write: 1'b0, addr: {page_ff, ptr_inc}, data: 8'h00};
              nxt_req_tgl = ~req_tgl_ff;
            end
          end
          else if (scl_fall)
          begin
            nxt_state = rack_ok_ff ? ST_RDATA : ST_IDLE;
            nxt_shift = tx_byte;
            nxt_drive = rack_ok_ff && !tx_byte[7];
            nxt_bitcnt = 4'h1;
          end
        end
      endcase
    end
  end

  // Link protocol registers.
  always_ff @(posedge smbus_link_clk)
  begin
    if (!lrst_s2_ff)
    begin
      state_ff <= ST_IDLE;
      after_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      drive_ff <= 1'b0;
      page_ff <= PAGE_RST;
      ptr_ff <= 8'h00;
      rack_ok_ff <= 1'b0;
      req_ff <= '0;
      req_tgl_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      after_ff <= nxt_after;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      drive_ff <= nxt_drive;
      page_ff <= nxt_page;
      ptr_ff <= nxt_ptr;
      rack_ok_ff <= nxt_rack_ok;
      req_ff <= nxt_req;
      req_tgl_ff <= nxt_req_tgl;
    end
  end

  // Open-drain data pin: only ever pulls low.
  assign smbus_serial_data_pin_o = 1'b0;
  assign smbus_serial_data_pin_oe = drive_ff;

endmodule : smbus_runtime_charger_regs

// ===== verif/charger_regs_sva.sv
// Port-level assertions for the run-time charger register bank.
`timescale 1ns/10ps
module charger_regs_sva
  import charger_regs_pkg::*;
(
  // Core clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // SMBus link pins.
  input wire logic smbus_link_clk,
  input wire logic smbus_clock_pin,
  input wire logic smbus_serial_data_pin_i,
  input wire logic smbus_serial_data_pin_o,
  input wire logic smbus_serial_data_pin_oe,
  input wire logic smbus_port_enabled,
  // Detector handshake and stored bytes.
  input wire logic detect_start,
  input wire logic [NUM_RW-1:0][7:0] control_bytes
);
  // A disabled port must never pull the data line.
  a_oe_needs_port: assert property (@(posedge clk) disable iff (!resetn)
    smbus_serial_data_pin_oe |-> smbus_port_enabled) else $error("data pulled while port off");
  // Open drain: the pin only ever pulls low.
  a_open_drain: assert property (@(posedge clk) disable iff (!resetn)
    !smbus_serial_data_pin_o) else $error("data pin driven high");
  // A start is one pulse, and at least eight cycles pass before the next one.
  a_start_pulse: assert property (@(posedge clk) disable iff (!resetn)
    detect_start |=> !detect_start [*8]) else $error("start pulse too long");
  // Starts only come through a live port.
  a_start_needs_port: assert property (@(posedge clk) disable iff (!resetn)
    detect_start |-> smbus_port_enabled) else $error("start without port");
  // Port state is decided once per reset.
  a_enable_holds: assert property (@(posedge clk) disable iff (!resetn)
    smbus_port_enabled |=> smbus_port_enabled) else $error("port dropped");
  // Enabling needs both lines pulled up.
  a_enable_pullups: assert property (@(posedge clk) disable iff (!resetn)
    $rose(smbus_port_enabled) |-> smbus_clock_pin && smbus_serial_data_pin_i) else $error("port on without pull-ups");
  // Stored bytes change only by bus writes.
  a_ctl_needs_port: assert property (@(posedge clk) disable iff (!resetn)
    $changed(control_bytes) |-> smbus_port_enabled) else $error("control byte changed without port");
  // Data must not move while the clock line is high, or it reads as start or stop.
  a_sda_stable_high: assert property (@(posedge smbus_link_clk) disable iff (!resetn)
    smbus_clock_pin [*3] |-> $stable(smbus_serial_data_pin_oe)) else $error("data moved with clock high");
  c_start: cover property (@(posedge clk) detect_start);
  c_port_on: cover property (@(posedge clk) $rose(smbus_port_enabled));
  c_answer: cover property (@(posedge smbus_link_clk) $rose(smbus_serial_data_pin_oe));
endmodule : charger_regs_sva

bind smbus_runtime_charger_regs charger_regs_sva u_sva (.clk(clk), .resetn(resetn),
  .smbus_link_clk(smbus_link_clk), .smbus_clock_pin(smbus_clock_pin),
  .smbus_serial_data_pin_i(smbus_serial_data_pin_i), .smbus_serial_data_pin_o(smbus_serial_data_pin_o),
  .smbus_serial_data_pin_oe(smbus_serial_data_pin_oe), .smbus_port_enabled(smbus_port_enabled),
  .detect_start(detect_start), .control_bytes(control_bytes));

// ===== verif/smbus_host_model.sv
// Behavioural SMBus host controller on the far side of the link.
`timescale 1ns/10ps
module smbus_host_model
(
  // Wire level of the shared data line.
  input wire logic sda,
  // Clock line and open-drain pull-down of the host.
  output logic scl,
  output logic sda_low
);
  // Quarter bit; each clock phase is two quarters, above the slave's minimum.
  localparam time Q = 360;
  // The clock stands high and data is released outside frames.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start: data falls while the clock is high.
  task start;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
  endtask : start
  // Repeated start from the low clock phase.
  task rstart;
    #Q;
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
  endtask : rstart
  // Stop: data rises while the clock is high, then bus-free time.
  task stop;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
    #(2*Q);
  endtask : stop
  // Data changes only in the low phase.
  task bit_out(input logic b);
    #Q;
    sda_low = ~b;
    #Q;
    scl = 1'b1;
    #(2*Q);
    scl = 1'b0;
  endtask : bit_out
  // Releases the line and samples in mid high phase.
  task bit_in(output logic b);
    #Q;
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    b = sda;
    #Q;
    scl = 1'b0;
  endtask : bit_in
  // One byte out, most significant bit first, then the slave's acknowledge.
  task byte_out(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(x);
    ack = ~x;
  endtask : byte_out
  // Holds the data line low as a board pull-down strap would, the clock line left high.
  task strap(input logic low);
    sda_low = low;
  endtask : strap
  // One byte in; more selects acknowledge, else a closing not-acknowledge.
  task byte_in(output logic [7:0] d, input logic more);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(~more);
  endtask : byte_in
endmodule : smbus_host_model

// ===== verif/smbus_runtime_charger_regs_bench.sv
// Self-checking bench for the SMBus run-time charger register bank.
`timescale 1ns/10ps
module smbus_runtime_charger_regs_bench
  import charger_regs_pkg::*;
;
  // Slave address of the device; the value is arbitrary.
  localparam logic [6:0] DEV = 7'h2d;
  logic clk, resetn, link_clk, scl, host_low, done, dis, vbus, conf, chg;
  logic [2:0] dtype;
  logic [3:0] cust;
  logic [3:0] pwr;
  logic [7:0] ocs;
  logic [7:0] rb [5];
  logic off_ack; // Acknowledge seen while the port is strapped off.
  wire sda_o, sda_oe, port_en, dstart;
  wire [NUM_RW-1:0][7:0] ctl;
  int err_total, checks, starts, cyc;
  // Pulled-up open-drain line: low while either party pulls it.
  wire sda = !(host_low || (sda_oe && !sda_o));
  // Per run: {charger, configured, vbus}, raw code, reported code, budget.
  logic [2:0] cond [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [2:0] raw [4] = '{TYPE_CDP, 3'h3, TYPE_CDP, 3'h6};
  logic [2:0] et [4] = '{TYPE_DCP, 3'h3, TYPE_CDP, 3'h6};
  logic [1:0] eb [4] = '{BUDGET_NONE, BUDGET_100MA, BUDGET_500MA, BUDGET_1A};

  smbus_runtime_charger_regs #(.SLAVE_ADDR(DEV)) u_dut (.clk(clk), .resetn(resetn), .smbus_link_clk(link_clk),
    .smbus_clock_pin(scl), .smbus_serial_data_pin_i(sda), .smbus_serial_data_pin_o(sda_o),
    .smbus_serial_data_pin_oe(sda_oe), .smbus_port_enabled(port_en), .detect_start(dstart),
    .detector_done(done), .detector_type(dtype), .detector_disabled(dis), .vbus_present(vbus),
    .device_configured(conf), .charger_found(chg), .custom_charge_status(cust), .port_power_on(pwr),
    .overcurrent_flags(ocs), .control_bytes(ctl));
  smbus_host_model u_host (.sda(sda), .scl(scl), .sda_low(host_low));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Link clock with an odd offset so it has no fixed phase to the core clock.
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  // Counts detector start pulses; the design holds each for one cycle.
  always @(posedge clk)
    if (dstart === 1'b1)
      starts <= starts + 1;
  // Cuts a hang short; the sequence needs about 80000 cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 98000)
    begin
      err_total++;
      $display("ERROR run_length expected 98000 seen more");
      results();
    end
  end

  task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  // Byte write: address, command as offset, one data byte, each acknowledged.
  task reg_wr(input logic [7:0] cmd, input logic [7:0] data);
    logic a;
    logic [7:0] b [3];
    b = '{{DEV, 1'b0}, cmd, data};
    u_host.start();
    for (int i = 0; i < 3; i++)
    begin
      u_host.byte_out(b[i], a);
      chk8("write ack", 8'h01, {7'h00, a});
    end
    u_host.stop();
  endtask : reg_wr
  // Read of n bytes from cmd upwards through the auto-incrementing pointer.
  task reg_rd(input logic [7:0] cmd, input int n);
    logic a;
    u_host.start();
    u_host.byte_out({DEV, 1'b0}, a);
    chk8("read addr ack", 8'h01, {7'h00, a});
    u_host.byte_out(cmd, a);
    chk8("read cmd ack", 8'h01, {7'h00, a});
    u_host.rstart();
    u_host.byte_out({DEV, 1'b1}, a);
    chk8("read addr ack", 8'h01, {7'h00, a});
    for (int i = 0; i < n; i++)
      u_host.byte_in(rb[i], i < n - 1);
    u_host.stop();
  endtask : reg_rd
  // Detector reports the end of a run with its raw code for one cycle.
  task finish_run(input logic [2:0] t);
    @(negedge clk);
    done = 1'b1;
    dtype = t;
    @(negedge clk);
    done = 1'b0;
  endtask : finish_run
  task results;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial
  begin
    resetn = 1'b0;
    done = 1'b0;
    dis = 1'b0;
    {chg, conf, vbus} = 3'h0;
    dtype = 3'h0;
    cust = 4'ha;
    pwr = 4'h5;
    ocs = 8'h3c;
    // Reset also spans four link clocks so the link side sees it.
    repeat (5) @(negedge clk);
    repeat (4) @(posedge link_clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (20) @(posedge link_clk);
    @(negedge clk);
    chk8("port enabled", 8'h01, {7'h00, port_en});
    reg_wr(PAGE_CMD, ADDR_RESULT[15:8]);
    reg_rd(ADDR_RESULT[7:0], 1);
    chk8("idle result", 8'h00, rb[0]);
    $display("test idle_read done");
    reg_wr(ADDR_MASK[7:0], 8'h07);
    chk8("mask byte", 8'h07, ctl[IDX_MASK]);
    reg_wr(ADDR_RESULT[7:0], 8'hf9);
    chk8("start pulses", 8'h01, starts[7:0]);
    reg_rd(ADDR_RESULT[7:0], 1);
    chk8("running result", 8'h09, rb[0]);
    $display("test start_running done");
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk);
      {chg, conf, vbus} = cond[k];
      if (k == 2)
        reg_wr(ADDR_MODE[7:0], 8'h01);
      if (k > 0)
        reg_wr(ADDR_RESULT[7:0], 8'h09);
      if (k == 1)
      begin
        reg_rd(ADDR_RESULT[7:0], 1);
        chk8("restart result", {TYPE_NOT_DONE, 1'b0, 1'b1, eb[k], 1'b1}, rb[0]);
      end
      finish_run(raw[k]);
      reg_rd(ADDR_RESULT[7:0], 1);
      chk8("run result", {et[k], 1'b1, 1'b1, eb[k], 1'b0}, rb[0]);
      $display("test detection_run %0d done", k);
    end
    chk8("start pulses", 8'h04, starts[7:0]);
    chk8("mode byte", 8'h01, ctl[IDX_MODE]);
    @(negedge clk);
    dis = 1'b1;
    reg_rd(ADDR_RESULT[7:0], 5);
    chk8("disabled result", {TYPE_DISABLED, 1'b1, 1'b1, BUDGET_1A, 1'b0}, rb[0]);
    chk8("custom control", RW_RST, rb[1]);
    chk8("custom status", {4'h0, cust}, rb[2]);
    chk8("port power", {3'h0, pwr, 1'b0}, rb[3]);
    chk8("overcurrent", ocs, rb[4]);
    $display("test status_burst done");
    // Second reset with the data line strapped low; the port must stay off and leave the bus unanswered.
    @(negedge clk);
    resetn = 1'b0;
    u_host.strap(1'b1);
    repeat (5) @(posedge link_clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (20) @(posedge link_clk);
    @(negedge clk);
    chk8("port disabled", 8'h00, {7'h00, port_en});
    u_host.strap(1'b0);
    repeat (80) @(negedge clk);
    u_host.start();
    u_host.byte_out({DEV, 1'b0}, off_ack);
    chk8("disabled ack", 8'h00, {7'h00, off_ack});
    u_host.stop();
    chk8("mask after reset", RW_RST, ctl[IDX_MASK]);
    $display("test strap_off done");
    results();
  end
endmodule : smbus_runtime_charger_regs_bench
